// [hdl/qvs_ctrl.sv]
// top of the quasi-resonant valley-skip and soft-start control core
//
// Summary of operation
// - supply turn-on stops charging, starts soft-start
// - soft-start is time based, 12ms, 4 steps
// - soft-start raises current limit lowest to full
// - on from zero-cross and counter; off from feedback
// - counter holds zero crossings to skip
// - evaluate feedback every 48ms, update counter
// - always below low threshold: count up to 7
// - above low, never above high: hold value
// - above high, never reset threshold: count down
// - above reset threshold: force counter to 1
// - counter saturates between 1 and 7
// - counter starts at 1
// - count thresholds follow line voltage level
// - zero-cross count 0..7, clears on gate high
// - after ringing time, on when count reaches counter
// - maximum off time forces gate on
// - current above feedback level turns gate off
`timescale 1ns/1ps
module qvs_ctrl
  import qvs_pkg::*;
#(
  parameter int unsigned SS_STEP_CYC = SOFTSTART_STEP_CYC,
  parameter int unsigned PERIOD_CYC = EVAL_CYC,
  parameter int unsigned RS_LONG_CYC = RING_LONG_CYC,
  parameter int unsigned RS_SHORT_CYC = RING_SHORT_CYC,
  parameter int unsigned OFF_MAX_CYC = OFFMAX_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  // supply above supply_turn_on_threshold
  input wire logic supply_on,
  // feedback_input comparators against counting thresholds
  input qvs_fb_cmp_t fb_cmp,
  // zero_cross_input comparator, high above 100mV
  input wire logic zero_cross_input,
  // zero-cross above ringing-suppression threshold
  input wire logic zc_above_rs,
  // current measurement above feedback_voltage
  input wire logic cs_above_fb,
  // line voltage high, selects upper threshold set
  input wire logic line_high,
  // startup charging cell enable
  output logic startup_cell_en,
  // power switch gate drive
  output logic gate_drive,
  // current-sense limit level code, 0 lowest 3 full
  output logic [1:0] cs_limit_level,
  // soft-start still in progress
  output logic soft_start_active,
  // counting threshold set select for the analog side
  output logic thr_set_high_line,
  // up/down counter value
  output logic [2:0] skip_count,
  // zero-crossing counter value
  output logic [2:0] zc_count
);
  qvs_phase_t phase_q; // operating phase
  logic ss_start; // one-cycle soft-start launch
  logic [1:0] ss_level; // sequencer level
  logic ss_done; // sequencer finished
  logic [2:0] udc; // up/down counter
  logic running; // switching allowed
  logic gate_q; // output flip-flop
  logic [2:0] zc_q; // zero-crossing counter
  logic zc_prev_q; // previous zero-cross sample
  logic zc_fall; // falling crossing seen
  logic [31:0] rs_q; // ringing suppression down-counter
  logic [31:0] off_q; // off-time counter
  logic rs_over; // ringing time elapsed
  logic set_on; // turn-on decision
  logic startup_q; // startup cell register
  logic [1:0] lvl_q; // output level register
  logic ssa_q; // soft-start active register
  logic thr_q; // threshold set register
  logic [2:0] skip_q; // counter copy register

  // phase control: turn-on starts soft-start, drop of supply returns to off
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase_q <= QVS_OFF;
    end else begin
      case (phase_q)
        QVS_OFF: begin
          if (supply_on) begin
            phase_q <= QVS_SOFT;
          end
        end
        QVS_SOFT: begin
          if (!supply_on) begin
            phase_q <= QVS_OFF;
          end else if (ss_done) begin
            phase_q <= QVS_RUN;
          end
        end
        QVS_RUN: begin
          if (!supply_on) begin
            phase_q <= QVS_OFF;
          end
        end
        default: begin
          phase_q <= QVS_OFF;
        end
      endcase
    end
  end

  assign ss_start = (phase_q == QVS_OFF) && supply_on;
  assign running = (phase_q != QVS_OFF);

  // soft-start sequencer
  qvs_softstart #(
    .STEP_CYC(SS_STEP_CYC)
  ) u_ss (
    .core_clk(core_clk),
    .rst(rst),
    .start(ss_start),
    .level(ss_level),
    .done(ss_done)
  );

  // valley-skip counter; held at minimum while not running
  qvs_updown #(
    .PERIOD_CYC(PERIOD_CYC)
  ) u_udc (
    .core_clk(core_clk),
    .rst(rst),
    .enable(running),
    .fb_cmp(fb_cmp),
    .count(udc)
  );

  // falling crossing of the zero-cross threshold
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      zc_prev_q <= 1'b0;
    end else begin
      zc_prev_q <= zero_cross_input;
    end
  end

  assign zc_fall = zc_prev_q && !zero_cross_input;

  // zero-crossing counter, only counts while switch is off
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      zc_q <= 3'h0;
    end else if (set_on || gate_q) begin
      zc_q <= 3'h0;
    end else if (zc_fall && zc_q != ZC_MAX) begin
      zc_q <= zc_q + 3'h1;
    end
  end

  // ringing suppression timer, loaded at turn-off, length from zero-cross level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rs_q <= 32'h0000_0000;
    end else if (gate_q) begin
      rs_q <= zc_above_rs ? RS_SHORT_CYC : RS_LONG_CYC;
    end else if (rs_q != 32'h0000_0000) begin
      rs_q <= rs_q - 32'h0000_0001;
    end
  end

  assign rs_over = (rs_q == 32'h0000_0000);

  // off-time counter for the maximum off time
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      off_q <= 32'h0000_0000;
    end else if (gate_q || !running) begin
      off_q <= 32'h0000_0000;
    end else if (off_q != OFF_MAX_CYC) begin
      off_q <= off_q + 32'h0000_0001;
    end
  end

  // switch-on decision: valley count reached, or off too long
  always_comb begin
    set_on = 1'b0;
    if (running && !gate_q) begin
      if (rs_over && (zc_q >= udc)) begin
        set_on = 1'b1;
      end else if (off_q == OFF_MAX_CYC) begin
        set_on = 1'b1;
      end
    end
  end

  // output flip-flop: set by digital on-decision, reset by current comparator
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gate_q <= 1'b0;
    end else if (!running) begin
      gate_q <= 1'b0;
    end else if (gate_q && cs_above_fb) begin
      gate_q <= 1'b0;
    end else if (set_on) begin
      gate_q <= 1'b1;
    end
  end

  // registered status and control outputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      startup_q <= 1'b1;
      lvl_q <= CS_LEVEL_FIRST;
      ssa_q <= 1'b0;
      thr_q <= 1'b0;
      skip_q <= UDC_MIN;
    end else begin
      startup_q <= !running && !supply_on;
      lvl_q <= (phase_q == QVS_RUN) ? CS_LEVEL_FULL : ss_level;
      ssa_q <= (phase_q == QVS_SOFT);
      thr_q <= line_high;
      skip_q <= udc;
    end
  end

  assign startup_cell_en = startup_q;
  assign gate_drive = gate_q;
  assign cs_limit_level = lvl_q;
  assign soft_start_active = ssa_q;
  assign thr_set_high_line = thr_q;
  assign skip_count = skip_q;
  assign zc_count = zc_q;
endmodule

// [hdl/qvs_pkg.sv]
// package with constants and types for the valley-skip soft-start controller
package qvs_pkg;
  // clock rate
  localparam int unsigned CLK_FREQ_HZ = 200_000_000;
  // soft-start total time and step count
  localparam int unsigned SOFTSTART_TIME_US = 12_000;
  localparam int unsigned SOFTSTART_STEPS = 4;
  localparam int unsigned SOFTSTART_STEP_CYC =
    (SOFTSTART_TIME_US / SOFTSTART_STEPS) * (CLK_FREQ_HZ / 1_000_000);
  // evaluation period of the up/down counter
  localparam int unsigned EVAL_TIME_US = 48_000;
  localparam int unsigned EVAL_CYC = EVAL_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  // ringing suppression times, long and short
  localparam int unsigned RING_LONG_NS = 25_000;
  localparam int unsigned RING_SHORT_NS = 2_500;
  localparam int unsigned RING_LONG_CYC = (RING_LONG_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned RING_SHORT_CYC = (RING_SHORT_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
  // maximum off time
  localparam int unsigned OFFMAX_TIME_US = 42;
  localparam int unsigned OFFMAX_CYC = OFFMAX_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  // counter widths and limits
  localparam int unsigned CNT_W = 3;
  localparam logic [2:0] UDC_MIN = 3'h1;
  localparam logic [2:0] UDC_MAX = 3'h7;
  localparam logic [2:0] ZC_MAX = 3'h7;
  // current-sense limit level codes: 0 lowest .. 3 full
  localparam logic [1:0] CS_LEVEL_FIRST = 2'h0;
  localparam logic [1:0] CS_LEVEL_FULL = 2'h3;

  // feedback comparator results
  typedef struct packed {
    logic above_reset;  // above counter_preset_threshold
    logic above_high;   // above count_down_threshold
    logic above_low;    // above count_up_threshold
  } qvs_fb_cmp_t;

  // controller operating phase
  typedef enum logic [1:0] {
    QVS_OFF = 2'b00,
    QVS_SOFT = 2'b01,
    QVS_RUN = 2'b10
  } qvs_phase_t;
endpackage

// [hdl/qvs_softstart.sv]
// soft-start sequencer stepping the current-sense limit selection
`timescale 1ns/1ps
module qvs_softstart
  import qvs_pkg::*;
#(
  parameter int unsigned STEP_CYC = SOFTSTART_STEP_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  output logic [1:0] level,
  output logic done
);
  logic [31:0] tmr_q; // step timer
  logic run_q; // sequence running
  logic [1:0] level_q; // current level code
  logic done_q; // last step at full level elapsed

  // equal-length steps advance the level until the full level holds
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tmr_q <= 32'h0000_0000;
      run_q <= 1'b0;
      level_q <= CS_LEVEL_FIRST;
      done_q <= 1'b0;
    end else if (start) begin
      // restart from lowest level
      tmr_q <= 32'h0000_0000;
      run_q <= 1'b1;
      level_q <= CS_LEVEL_FIRST;
      done_q <= 1'b0;
    end else if (run_q) begin
      if (tmr_q == STEP_CYC - 1) begin
        tmr_q <= 32'h0000_0000;
        if (level_q == CS_LEVEL_FULL) begin
          // last step elapsed, hold full level
          run_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          level_q <= level_q + 2'h1;
        end
      end else begin
        tmr_q <= tmr_q + 32'h0000_0001;
      end
    end
  end

  assign level = level_q;
  assign done = done_q;
endmodule

// [hdl/qvs_updown.sv]
// up/down counter of zero crossings to skip, updated once per period
`timescale 1ns/1ps
module qvs_updown
  import qvs_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = EVAL_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable,
  input qvs_fb_cmp_t fb_cmp,
  output logic [2:0] count
);
  logic [31:0] tmr_q; // period timer
  logic tick; // one-cycle period enable
  qvs_fb_cmp_t seen_q; // sticky comparator flags
  logic [2:0] cnt_q; // skip count

  assign tick = enable && (tmr_q == PERIOD_CYC - 1);

  // period divider
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tmr_q <= 32'h0000_0000;
    end else if (!enable || tick) begin
      tmr_q <= 32'h0000_0000;
    end else begin
      tmr_q <= tmr_q + 32'h0000_0001;
    end
  end

  // sticky flags, cleared at period start; current sample lands in new period
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seen_q <= '0;
    end else if (!enable || tick) begin
      seen_q <= enable ? fb_cmp : '0;
    end else begin
      seen_q <= seen_q | fb_cmp;
    end
  end

  // counter decision at end of each period, saturating 1..7
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= UDC_MIN;
    end else if (!enable) begin
      cnt_q <= UDC_MIN;
    end else if (tick) begin
      if (seen_q.above_reset || fb_cmp.above_reset) begin
        cnt_q <= UDC_MIN;
      end else if (seen_q.above_high || fb_cmp.above_high) begin
        if (cnt_q != UDC_MIN) begin
          cnt_q <= cnt_q - 3'h1;
        end
      end else if (seen_q.above_low || fb_cmp.above_low) begin
        cnt_q <= cnt_q;
      end else if (cnt_q != UDC_MAX) begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  assign count = cnt_q;
endmodule

// [tb/qvs_ctrl_assertions.sv]
// concurrent checks on the control core ports
`timescale 1ns/1ps
module qvs_ctrl_assertions
  import qvs_pkg::*;
#(
  parameter int unsigned OFF_MAX_CYC = OFFMAX_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic supply_on,
  input wire logic cs_above_fb,
  input wire logic startup_cell_en,
  input wire logic gate_drive,
  input wire logic [1:0] cs_limit_level,
  input wire logic soft_start_active,
  input wire logic [2:0] skip_count,
  input wire logic [2:0] zc_count
);
  // longest wait for a forced switch-on, with some slack
  localparam int OFF_HI = OFF_MAX_CYC + 4;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // supply turn-on while the charging cell still runs
  sequence s_turn_on;
    $rose(supply_on) && startup_cell_en;
  endsequence
  // soft-start flag up two cycles later
  sequence s_ss_up;
    ##2 soft_start_active;
  endsequence
  // gate held off for the first two cycles after turn-off
  sequence s_ring_hold;
    !gate_drive [*2];
  endsequence
  chk_ss_begin: assert property (s_turn_on |-> s_ss_up)
    else $error("soft-start did not begin");
  chk_cell_off: assert property (supply_on |=> !startup_cell_en)
    else $error("charging cell still on");
  chk_skip_range: assert property (skip_count >= UDC_MIN && skip_count <= UDC_MAX)
    else $error("skip count out of range");
  chk_skip_step: assert property (skip_count != $past(skip_count) |->
    skip_count == UDC_MIN || skip_count == $past(skip_count) + 3'h1 ||
    skip_count == $past(skip_count) - 3'h1) else $error("skip count jumped");
  chk_gate_off: assert property (gate_drive && cs_above_fb |=> !gate_drive)
    else $error("gate not turned off");
  chk_zc_clear: assert property (gate_drive ##1 gate_drive |-> zc_count == 3'h0)
    else $error("crossing count not cleared");
  chk_ring_hold: assert property ($fell(gate_drive) |-> s_ring_hold)
    else $error("gate on during ringing time");
  chk_off_max: assert property ($fell(gate_drive) |->
    ##[1:OFF_HI] (gate_drive || !supply_on)) else $error("off time too long");
  chk_level_step: assert property (cs_limit_level != $past(cs_limit_level) |->
    cs_limit_level == 2'h0 || cs_limit_level == $past(cs_limit_level) + 2'h1)
    else $error("limit level jumped");
endmodule

bind qvs_ctrl qvs_ctrl_assertions #(.OFF_MAX_CYC(OFF_MAX_CYC)) i_chk (
  .core_clk(core_clk), .rst(rst), .supply_on(supply_on), .cs_above_fb(cs_above_fb),
  .startup_cell_en(startup_cell_en), .gate_drive(gate_drive),
  .cs_limit_level(cs_limit_level), .soft_start_active(soft_start_active),
  .skip_count(skip_count), .zc_count(zc_count));

// [tb/qvs_partner.sv]
// comparator and switch model around the control core
`timescale 1ns/1ps
module qvs_partner
  import qvs_pkg::*;
(
  input wire logic core_clk,
  input wire logic gate_drive,
  input wire logic [1:0] fb_lvl,
  input wire logic [3:0] rings,
  output qvs_fb_cmp_t fb_cmp,
  output logic zero_cross_input,
  output logic cs_above_fb
);
  logic [7:0] on_q = 8'h00; // cycles with the switch on
  logic [7:0] off_q = 8'h00; // cycles with the switch off
  // time the on and off phases of the switch
  always_ff @(posedge core_clk) begin
    on_q <= gate_drive ? on_q + 8'h01 : 8'h00;
    off_q <= gate_drive ? 8'h00 : off_q + 8'h01;
  end
  // current ramp passes the feedback level five cycles after switch-on
  assign cs_above_fb = gate_drive && on_q >= 8'h05;
  // ringing: one falling crossing every four cycles, clamped low while on
  assign zero_cross_input = !gate_drive && off_q < {2'h0, rings, 2'h0} && off_q[1];
  // feedback level 0..3 against the three counting thresholds
  assign fb_cmp = '{above_reset: fb_lvl == 2'h3, above_high: fb_lvl >= 2'h2,
    above_low: fb_lvl != 2'h0};
endmodule

// [tb/testbench.sv]
// self-checking bench for the valley-skip soft-start control core
`timescale 1ns/1ps
module testbench;
  import qvs_pkg::*;
  localparam int unsigned OFFM = 60; // shortened maximum off time
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic supply_on = 1'b0;
  logic line_high = 1'b0;
  logic zc_above_rs = 1'b1; // short ringing time except during the long ringing check
  logic [1:0] fb_lvl = 2'h0; // feedback level seen by the comparators
  logic [3:0] rings = 4'h8; // falling crossings per off phase
  qvs_fb_cmp_t fb_cmp;
  logic zero_cross_input, cs_above_fb, startup_cell_en, gate_drive;
  logic soft_start_active, thr_set_high_line;
  logic [1:0] cs_limit_level;
  logic [2:0] skip_count, zc_count, last;
  int off;
  int bad_count = 0;
  int n_compared = 0;
  qvs_ctrl #(.SS_STEP_CYC(20), .PERIOD_CYC(50), .RS_LONG_CYC(10), .RS_SHORT_CYC(3),
    .OFF_MAX_CYC(OFFM)) i_qvs_ctrl (.core_clk(core_clk), .rst(rst), .supply_on(supply_on),
    .fb_cmp(fb_cmp), .zero_cross_input(zero_cross_input), .zc_above_rs(zc_above_rs),
    .cs_above_fb(cs_above_fb), .line_high(line_high), .startup_cell_en(startup_cell_en),
    .gate_drive(gate_drive), .cs_limit_level(cs_limit_level),
    .soft_start_active(soft_start_active), .thr_set_high_line(thr_set_high_line),
    .skip_count(skip_count), .zc_count(zc_count));
  qvs_partner i_qvs_partner (.core_clk(core_clk), .gate_drive(gate_drive), .fb_lvl(fb_lvl),
    .rings(rings), .fb_cmp(fb_cmp), .zero_cross_input(zero_cross_input),
    .cs_above_fb(cs_above_fb));
  // 200 MHz clock
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  // compare one value with its expectation
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // counts, verdict and end of run
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // a wait that ran out ends the run
  task automatic timeout();
    bad_count++;
    complete_run();
  endtask
  // step to just after the next rising edge
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  // wait for a skip count value
  task automatic wait_val(input logic [2:0] v);
    int i;
    for (i = 0; i < 400 && skip_count !== v; i++) tick();
    if (i == 400) timeout();
  endtask
  // wait for the skip count to move away from its present value, then check it
  task automatic wait_skip(input logic [2:0] exp);
    logic [2:0] old;
    int i;
    old = skip_count;
    for (i = 0; i < 400 && skip_count === old; i++) tick();
    if (i == 400) timeout();
    cmp(skip_count, exp);
  endtask
  // wait for gate level v; crossing count just before and cycles taken
  task automatic wait_gate(input logic v, output logic [2:0] lz, output int n);
    lz = zc_count;
    for (n = 0; n < 300 && gate_drive !== v; n++) begin
      lz = zc_count;
      tick();
    end
    if (n == 300) timeout();
  endtask
  // one full off phase with n crossings of ringing
  task automatic t_gate(input logic [3:0] n);
    @(posedge core_clk) rings <= n;
    wait_gate(1'b1, last, off);
    wait_gate(1'b0, last, off);
    wait_gate(1'b1, last, off);
  endtask
  // turn-on and the four soft-start steps
  task automatic t_soft();
    int i;
    @(posedge core_clk) supply_on <= 1'b1;
    for (i = 1; i <= 95; i++) begin
      tick();
      if (i == 3) cmp(startup_cell_en, 1'b0);
      if (i == 5) cmp(soft_start_active, 1'b1);
      if (i % 20 == 12 && i < 80) cmp(cs_limit_level, 8'(i / 20));
      if (i == 75) cmp(soft_start_active, 1'b1);
    end
    cmp(soft_start_active, 1'b0);
    cmp(cs_limit_level, CS_LEVEL_FULL);
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    tick();
    cmp(startup_cell_en, 1'b1);
    cmp(skip_count, UDC_MIN);
    cmp(zc_count, 3'h0);
    t_soft();
    wait_val(UDC_MAX);
    repeat (120) tick();
    cmp(skip_count, UDC_MAX);
    @(posedge core_clk) fb_lvl <= 2'h1;
    repeat (120) tick();
    cmp(skip_count, UDC_MAX);
    t_gate(4'h9);
    cmp(last, 3'h7);
    t_gate(4'h3);
    cmp(last, 3'h3);
    cmp(off >= OFFM - 3 && off <= OFFM + 4, 1'b1);
    @(posedge core_clk) fb_lvl <= 2'h2;
    wait_skip(3'h6);
    wait_skip(3'h5);
    @(posedge core_clk) fb_lvl <= 2'h3;
    wait_skip(UDC_MIN);
    t_gate(4'h8);
    cmp(last, 3'h1);
    // long ringing time holds the gate off at least ten cycles
    @(posedge core_clk) zc_above_rs <= 1'b0;
    t_gate(4'h8);
    cmp(off >= 10, 1'b1);
    @(posedge core_clk) zc_above_rs <= 1'b1;
    @(posedge core_clk) fb_lvl <= 2'h2;
    repeat (120) tick();
    cmp(skip_count, UDC_MIN);
    @(posedge core_clk) fb_lvl <= 2'h0;
    @(posedge core_clk) line_high <= 1'b1;
    wait_skip(3'h2);
    cmp(thr_set_high_line, 1'b1);
    @(posedge core_clk) supply_on <= 1'b0;
    repeat (3) tick();
    cmp(skip_count, UDC_MIN);
    cmp(gate_drive, 1'b0);
    complete_run();
  end
endmodule
